/* hw/msf_filter_range_config.sv */
`timescale 1ns/1ps
`default_nettype none
// Function
// [R1] FIFO policy bit: 1 drops new writes when full, 0 overwrites oldest.
// [R2] Sync slot field: 0 off, 1..7 pick temp, gyro xyz, accel xyz low bit0.
// [R3] Frame sync latched; toggles once, then held until sample strobe captures it.
// [R4] Lowpass setting applies only when bypass field is 00.
// [R5] Rate: bypass bit0 or 10 gives 32k; 00 with 0/7 8k; else 1k.
// [R6] Bypass field is gyro range bits 1:0; nonzero bypasses the filter.
// [R7] Gyro range field selects 250, 500, 1000, 2000 dps.
// [R8] Accel range field selects 2, 4, 8, 16 g.
// [R9] Range bits 7..5 are X, Y, Z self-test; reserved bits read zero.
// [R10] Rate divider acts only with bypass 00 and lowpass 1..6.
// [R11] Divided strobe is 1 kHz over one plus divider; it captures frame sync.
module msf_filter_range_config #(
   parameter int TICKS_32K = msf_pkg::TICKS_32K,
   parameter int TICKS_8K = msf_pkg::TICKS_8K,
   parameter int TICKS_1K = msf_pkg::TICKS_1K
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Register port
   input wire logic regWrEn,
   input wire logic regRdEn,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWrData,
   output logic [7:0] regRdData,
   output logic regRdValid,
   // Frame sync pin
   input wire logic frameSyncInput,
   // FIFO steering
   output logic fifoFullPolicy,
   // Filter and rate
   output logic lowpassActive,
   output logic [2:0] lowpassSelect,
   output logic [1:0] filterBypassSelect,
   output logic [1:0] outputRate,
   output logic sampleStrobe,
   // Ranges and self-test
   output logic [1:0] gyroRangeSelect,
   output logic [1:0] accelRangeSelect,
   output logic [2:0] gyroSelftest,
   output logic [2:0] accelSelftest,
   // Frame sync tag into output data low bytes (temp, gx, gy, gz, ax, ay, az)
   output logic [6:0] syncTagBits
);
   localparam int CW = $clog2(TICKS_1K * 256 + 1);

   // Refuse tick counts the strobe counter cannot serve
   if (TICKS_32K < 1 || TICKS_8K < TICKS_32K || TICKS_1K < TICKS_8K) begin : g_bad_ticks
      $error("msf_filter_range_config: tick counts must be ordered and positive");
   end

   // Write decode; writes are masked per register
   function automatic logic [7:0] wr_mask(input logic [7:0] addr);
      case (addr)
         msf_pkg::REG_RATE_DIVIDER: wr_mask = 8'hff;
         msf_pkg::REG_FILTER_SYNC: wr_mask = msf_pkg::MASK_FILTER_SYNC;
         msf_pkg::REG_GYRO_RANGE: wr_mask = msf_pkg::MASK_GYRO_RANGE;
         msf_pkg::REG_ACCEL_RANGE: wr_mask = msf_pkg::MASK_ACCEL_RANGE;
         default: wr_mask = 8'h00;
      endcase
   endfunction : wr_mask

   // Index inside the store
   function automatic logic [1:0] reg_idx(input logic [7:0] addr);
      reg_idx = 2'(addr - msf_pkg::REG_RATE_DIVIDER);
   endfunction : reg_idx

   function automatic logic mapped(input logic [7:0] addr);
      mapped = (addr >= msf_pkg::REG_RATE_DIVIDER) && (addr <= msf_pkg::REG_ACCEL_RANGE);
   endfunction : mapped

   logic [31:0] allRegs;
   logic [7:0] storeRd;
   logic [7:0] rateDivider;
   logic [7:0] filterSync;
   logic [7:0] gyroRange;
   logic [7:0] accelRange;
   logic rdMapped_q;
   logic rdMapped_d;
   logic rdValid_q;
   logic rdValid_d;

   // Register storage, reserved bits forced to zero on write
   msf_reg_store #(
      .DEPTH(4)
   ) u_store (
      .ref_clk(ref_clk),
      .rst(rst),
      .wrEn(regWrEn && mapped(regAddr)),
      .wrIdx(reg_idx(regAddr)),
      .wrData(regWrData & wr_mask(regAddr)), // [R9]
      .rdIdx(reg_idx(regAddr)),
      .rdData(storeRd),
      .allData(allRegs)
   );

   assign rateDivider = allRegs[7:0];
   assign filterSync = allRegs[15:8];
   assign gyroRange = allRegs[23:16];
   assign accelRange = allRegs[31:24];

   // Read answer one cycle after request; unmapped reads return zero
   always_comb begin
      rdMapped_d = regRdEn && mapped(regAddr);
      rdValid_d = regRdEn;
   end
   always_ff @(posedge ref_clk) begin
      rdMapped_q <= rst ? 1'b0 : rdMapped_d;
      rdValid_q <= rst ? 1'b0 : rdValid_d;
   end
   assign regRdData = rdMapped_q ? storeRd : 8'h00;
   assign regRdValid = rdValid_q;

   // Decoded configuration fields
   logic [2:0] syncSlot;
   logic divEffective;
   msf_pkg::msf_rate_type rate;
   always_comb begin
      fifoFullPolicy = filterSync[msf_pkg::FIFO_POLICY_BIT]; // [R1]
      syncSlot = filterSync[msf_pkg::SYNC_SLOT_LSB +: 3]; // [R2]
      lowpassSelect = filterSync[msf_pkg::LOWPASS_LSB +: 3];
      filterBypassSelect = gyroRange[msf_pkg::BYPASS_LSB +: 2]; // [R6]
      lowpassActive = (filterBypassSelect == 2'b00); // [R4] [R6]
      gyroRangeSelect = gyroRange[msf_pkg::RANGE_LSB +: 2]; // [R7]
      accelRangeSelect = accelRange[msf_pkg::RANGE_LSB +: 2]; // [R8]
      gyroSelftest = {gyroRange[msf_pkg::SELFTEST_X_BIT], gyroRange[msf_pkg::SELFTEST_Y_BIT],
                      gyroRange[msf_pkg::SELFTEST_Z_BIT]}; // [R9]
      accelSelftest = {accelRange[msf_pkg::SELFTEST_X_BIT], accelRange[msf_pkg::SELFTEST_Y_BIT],
                       accelRange[msf_pkg::SELFTEST_Z_BIT]}; // [R9]
      // Output rate selection
      if (filterBypassSelect[0] || filterBypassSelect == 2'b10) begin
         rate = msf_pkg::RATE_SEL_32K; // [R5]
      end else if (lowpassSelect == 3'd0 || lowpassSelect == 3'd7) begin
         rate = msf_pkg::RATE_SEL_8K; // [R5]
      end else begin
         rate = msf_pkg::RATE_SEL_1K; // [R5]
      end
      divEffective = (rate == msf_pkg::RATE_SEL_1K); // [R10]
      outputRate = rate;
   end

   // Sample strobe period in clock ticks
   function automatic logic [CW-1:0] period(input msf_pkg::msf_rate_type r,
                                            input logic [7:0] div);
      case (r)
         msf_pkg::RATE_SEL_32K: period = CW'(TICKS_32K);
         msf_pkg::RATE_SEL_8K: period = CW'(TICKS_8K);
         default: period = CW'(TICKS_1K * (int'(div) + 1)); // [R11]
      endcase
   endfunction : period

   // Strobe generator
   logic [CW-1:0] tick_q;
   logic [CW-1:0] tick_d;
   logic strobe_q;
   logic strobe_d;
   logic [CW-1:0] per;
   always_comb begin
      per = period(rate, divEffective ? rateDivider : 8'h00); // [R10]
      strobe_d = 1'b0;
      if (tick_q + CW'(1) >= per) begin
         tick_d = '0;
         strobe_d = 1'b1; // [R11]
      end else begin
         tick_d = tick_q + CW'(1);
      end
   end
   always_ff @(posedge ref_clk) begin
      tick_q <= rst ? '0 : tick_d;
      strobe_q <= rst ? 1'b0 : strobe_d;
   end
   assign sampleStrobe = strobe_q;

   // Frame sync latch: one toggle held until the strobe captures it
   logic pinPrev_q;
   logic pinPrev_d;
   logic latched_q;
   logic latched_d;
   logic armed_q;
   logic armed_d;
   logic tag_q;
   logic tag_d;
   always_comb begin
      pinPrev_d = frameSyncInput;
      latched_d = latched_q;
      armed_d = armed_q;
      tag_d = tag_q;
      if (armed_q && frameSyncInput != pinPrev_q) begin
         latched_d = ~latched_q; // [R3]
         armed_d = 1'b0;
      end
      if (strobe_q) begin
         tag_d = latched_d; // [R3] [R11]
         armed_d = 1'b1;
      end
   end
   always_ff @(posedge ref_clk) begin
      pinPrev_q <= rst ? 1'b0 : pinPrev_d;
      latched_q <= rst ? 1'b0 : latched_d;
      armed_q <= rst ? 1'b1 : armed_d;
      tag_q <= rst ? 1'b0 : tag_d;
   end

   // Route captured bit to the selected low byte
   logic [6:0] tag_bits_d;
   logic [6:0] tagBits_q;
   always_comb begin
      tag_bits_d = 7'h00;
      if (syncSlot != 3'd0) begin
         tag_bits_d[syncSlot - 3'd1] = tag_q; // [R2]
      end
   end
   always_ff @(posedge ref_clk) begin
      tagBits_q <= rst ? 7'h00 : tag_bits_d;
   end
   assign syncTagBits = tagBits_q;
endmodule : msf_filter_range_config
`default_nettype wire

/* hw/msf_pkg.sv */
package msf_pkg;
   // Register offsets on the internal register port
   localparam logic [7:0] REG_RATE_DIVIDER = 8'h19;
   localparam logic [7:0] REG_FILTER_SYNC = 8'h1a;
   localparam logic [7:0] REG_GYRO_RANGE = 8'h1b;
   localparam logic [7:0] REG_ACCEL_RANGE = 8'h1c;
   // Reset values
   localparam logic [7:0] RST_RATE_DIVIDER = 8'h00;
   localparam logic [7:0] RST_FILTER_SYNC = 8'h00;
   localparam logic [7:0] RST_GYRO_RANGE = 8'h00;
   localparam logic [7:0] RST_ACCEL_RANGE = 8'h00;
   // Writable bit masks; other bits read zero
   localparam logic [7:0] MASK_FILTER_SYNC = 8'h7f;
   localparam logic [7:0] MASK_GYRO_RANGE = 8'hfb;
   localparam logic [7:0] MASK_ACCEL_RANGE = 8'hf8;
   // Field positions
   localparam int FIFO_POLICY_BIT = 6;
   localparam int SYNC_SLOT_LSB = 3;
   localparam int LOWPASS_LSB = 0;
   localparam int BYPASS_LSB = 0;
   localparam int RANGE_LSB = 3;
   localparam int SELFTEST_X_BIT = 7;
   localparam int SELFTEST_Y_BIT = 6;
   localparam int SELFTEST_Z_BIT = 5;
   // Timing: base rates and clock
   localparam int CLOCK_HZ = 20000000;
   localparam int RATE_32K_HZ = 32000;
   localparam int RATE_8K_HZ = 8000;
   localparam int RATE_1K_HZ = 1000;
   localparam int TICKS_32K = CLOCK_HZ / RATE_32K_HZ;
   localparam int TICKS_8K = CLOCK_HZ / RATE_8K_HZ;
   localparam int TICKS_1K = CLOCK_HZ / RATE_1K_HZ;
   // Output rate selections
   typedef enum logic [1:0] {
      RATE_SEL_32K,
      RATE_SEL_8K,
      RATE_SEL_1K
   } msf_rate_type;
endpackage : msf_pkg

/* hw/msf_reg_store.sv */
`timescale 1ns/1ps
`default_nettype none
// Small register store: one byte per slot, registered read data
module msf_reg_store #(
   parameter int DEPTH = 4
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Write side
   input wire logic wrEn,
   input wire logic [$clog2(DEPTH)-1:0] wrIdx,
   input wire logic [7:0] wrData,
   // Read side
   input wire logic [$clog2(DEPTH)-1:0] rdIdx,
   output logic [7:0] rdData,
   // Whole content for steering logic
   output logic [DEPTH*8-1:0] allData
);
   logic [7:0] mem_q [DEPTH];
   logic [7:0] mem_d [DEPTH];
   logic [7:0] rdData_d;

   // Refuse a store too small for index arithmetic
   if (DEPTH < 2) begin : g_bad_depth
      $error("msf_reg_store: DEPTH must be at least 2");
   end

   // Next content and read word
   always_comb begin
      for (int i = 0; i < DEPTH; i++) begin
         mem_d[i] = mem_q[i];
      end
      if (wrEn) begin
         mem_d[wrIdx] = wrData;
      end
      rdData_d = mem_q[rdIdx];
   end

   // Registers, all cleared at reset
   always_ff @(posedge ref_clk) begin
      for (int i = 0; i < DEPTH; i++) begin
         mem_q[i] <= rst ? 8'h00 : mem_d[i];
      end
      rdData <= rst ? 8'h00 : rdData_d;
   end

   // Flat view
   always_comb begin
      for (int i = 0; i < DEPTH; i++) begin
         allData[i*8 +: 8] = mem_q[i];
      end
   end
endmodule : msf_reg_store
`default_nettype wire

/* verification/msf_filter_range_config_chk.sv */
`timescale 1ns/1ps
`default_nettype none
// Port checks for the config block
module msf_filter_range_config_chk #(
   parameter int TICKS_32K = 2
) (
   // Clock, reset, register port
   input wire logic ref_clk, rst, regWrEn, regRdEn, regRdValid,
   input wire logic [7:0] regAddr, regWrData, regRdData,
   // Decoded outputs
   input wire logic fifoFullPolicy, lowpassActive, sampleStrobe,
   input wire logic [2:0] lowpassSelect,
   input wire logic [1:0] filterBypassSelect, outputRate, gyroRangeSelect, accelRangeSelect,
   // Frame sync tags
   input wire logic [6:0] syncTagBits
);
   int gap_d, gap_q;
   logic steady_d, steady_q, wrF, wrG, wrA;
   logic [1:0] wantRate;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   // Write decode, expected rate, strobe gap and 32k run
   always_comb begin
      wrF = regWrEn && regAddr == 8'h1a;
      wrG = regWrEn && regAddr == 8'h1b;
      wrA = regWrEn && regAddr == 8'h1c;
      wantRate = (lowpassSelect == 3'h0 || lowpassSelect == 3'h7) ? 2'h1 : 2'h2;
      if (filterBypassSelect != 2'h0) wantRate = 2'h0;
      gap_d = sampleStrobe ? 1 : gap_q + 1;
      steady_d = (sampleStrobe || steady_q) && outputRate == 2'h0;
   end
   always_ff @(posedge ref_clk) begin
      gap_q <= rst ? 0 : gap_d;
      steady_q <= rst ? 1'b0 : steady_d;
   end
   property p_pol; wrF |=> fifoFullPolicy == $past(regWrData[6]); endproperty
   a_pol: assert property (p_pol) else $error("policy bit wrong");
   property p_lp; lowpassActive == (filterBypassSelect == 2'h0); endproperty
   a_lp: assert property (p_lp) else $error("filter flag wrong");
   property p_rt; outputRate == wantRate; endproperty
   a_rt: assert property (p_rt) else $error("rate code wrong");
   property p_st; sampleStrobe && steady_q |-> gap_q == TICKS_32K; endproperty
   a_st: assert property (p_st) else $error("fast strobe period wrong");
   property p_wg; wrG |=> filterBypassSelect == $past(regWrData[1:0]); endproperty
   a_wg: assert property (p_wg) else $error("bypass field wrong");
   property p_rg; wrG |=> gyroRangeSelect == $past(regWrData[4:3]); endproperty
   a_rg: assert property (p_rg) else $error("gyro range wrong");
   property p_ra; wrA |=> accelRangeSelect == $past(regWrData[4:3]); endproperty
   a_ra: assert property (p_ra) else $error("accel range wrong");
   property p_rv; regRdEn && regAddr == 8'h1c |=> regRdValid && regRdData[2:0] == 3'h0; endproperty
   a_rv: assert property (p_rv) else $error("reserved bits read back");
   property p_tg; $onehot0(syncTagBits); endproperty
   a_tg: assert property (p_tg) else $error("sync tag in more than one slot");
   // Main scenarios
   c_slow: cover property (sampleStrobe && outputRate == 2'h2);
   c_fast: cover property (sampleStrobe && steady_q);
   c_pol: cover property (wrF);
   c_tag: cover property (syncTagBits != 7'h00);
endmodule : msf_filter_range_config_chk
`default_nettype wire

/* verification/msf_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Host on the register port; drives just after the falling edge
module msf_host_model (
   // Clock
   input wire logic ref_clk,
   // Register port
   output logic regWrEn, regRdEn,
   output logic [7:0] regAddr, regWrData,
   input wire logic [7:0] regRdData
);
   // Idle port at time zero
   initial begin
      {regWrEn, regRdEn, regAddr, regWrData} = 18'h0;
   end
   // One access taken at the next rising edge; read data taken in the valid cycle
   task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] wd,
                       output logic [7:0] rd);
      @(negedge ref_clk);
      {regAddr, regWrData} = {a, wd};
      {regWrEn, regRdEn} = {w, !w};
      @(negedge ref_clk);
      {regWrEn, regRdEn} = 2'b00;
      {regAddr, regWrData} = ~{a, wd};
      rd = regRdData;
   endtask : xfer
endmodule : msf_host_model
`default_nettype wire

/* verification/msf_filter_range_config_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
// Host model on the register port; frame sync pin driven here
module msf_filter_range_config_tb_top;
   logic ref_clk, rst, frameSyncInput, regWrEn, regRdEn, regRdValid, fifoFullPolicy;
   logic lowpassActive, sampleStrobe;
   logic [7:0] regAddr, regWrData, regRdData, d;
   logic [2:0] lowpassSelect, gyroSelftest, accelSelftest;
   logic [1:0] filterBypassSelect, outputRate, gyroRangeSelect, accelRangeSelect;
   logic [6:0] syncTagBits;
   int errors = 0;
   int checks_done = 0;
   // Shortened rate counts of 2, 4 and 8 cycles
   msf_filter_range_config #(.TICKS_32K(2), .TICKS_8K(4), .TICKS_1K(8)) i_dut (
      .ref_clk, .rst, .regWrEn, .regRdEn, .regAddr, .regWrData, .regRdData, .regRdValid,
      .frameSyncInput, .fifoFullPolicy, .lowpassActive, .lowpassSelect, .filterBypassSelect,
      .outputRate, .sampleStrobe, .gyroRangeSelect, .accelRangeSelect, .gyroSelftest,
      .accelSelftest, .syncTagBits);
   msf_host_model i_host (.ref_clk, .regWrEn, .regRdEn, .regAddr, .regWrData, .regRdData);
   // Free-running clock
   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end
   // Compare and count
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask : chk
   // Verdict and end of run
   task automatic stop_test();
      if (errors == 0 && checks_done > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : stop_test
   // Cycles between the next two strobes
   task automatic period(output int n);
      repeat (2) begin
         n = 0;
         do begin
            @(negedge ref_clk);
            n++;
         end while (sampleStrobe !== 1'b1 && n < 900);
         if (n >= 900) errors++;
      end
   endtask : period
   // Reset values, then all ones: reserved bits and the unmapped place read zero
   task automatic t_regs();
      logic [7:0] want [4] = '{8'h7f, 8'hfb, 8'hf8, 8'h00};
      for (int i = 0; i < 4; i++) begin
         i_host.xfer(1'b0, 8'(8'h1a + i), 8'h00, d);
         chk(d, 8'h00);
         i_host.xfer(1'b1, 8'(8'h1a + i), 8'hff, d);
         i_host.xfer(1'b0, 8'(8'h1a + i), 8'h00, d);
         chk(d, want[i]);
      end
      chk(8'({fifoFullPolicy, gyroSelftest, accelSelftest}), 8'h7f);
      chk(8'({gyroRangeSelect, accelRangeSelect}), 8'h0f);
   endtask : t_regs
   // All bypass and lowpass pairs with divider 1: decode and strobe period
   task automatic t_rates();
      logic [1:0] r;
      int n;
      i_host.xfer(1'b1, 8'h19, 8'h01, d);
      i_host.xfer(1'b0, 8'h19, 8'h00, d);
      chk(d, 8'h01);
      for (int b = 0; b < 4; b++) begin
         for (int l = 0; l < 8; l++) begin
            i_host.xfer(1'b1, 8'h1b, 8'(b), d);
            i_host.xfer(1'b1, 8'h1a, 8'(l), d);
            r = b != 0 ? 2'h0 : (l == 0 || l == 7) ? 2'h1 : 2'h2;
            chk(8'({lowpassSelect, lowpassActive, filterBypassSelect}),
                8'({3'(l), b == 0, 2'(b)}));
            chk(8'(outputRate), 8'(r));
            period(n);
            chk(8'(n), 8'(r == 2'h2 ? 16 : 2 << r));
         end
      end
   endtask : t_rates
   // Short pulse per slot; its fall before the capture must not toggle again
   task automatic t_sync();
      logic want;
      logic [6:0] keep;
      int s;
      int n;
      want = 1'b0;
      i_host.xfer(1'b1, 8'h1b, 8'h00, d);
      for (int i = 1; i < 9; i++) begin
         s = i % 8;
         i_host.xfer(1'b1, 8'h1a, 8'(s * 8 + 1), d);
         period(n);
         keep = syncTagBits;
         @(negedge ref_clk);
         frameSyncInput = 1'b1;
         @(negedge ref_clk);
         frameSyncInput = 1'b0;
         want = !want;
         period(n);
         if (s == 0) chk(8'(syncTagBits), 8'(keep));
         else chk(8'(syncTagBits), 8'(want) << (s - 1));
      end
   endtask : t_sync
   // Reset for 16 cycles, then the scenarios
   initial begin
      rst = 1'b1;
      frameSyncInput = 1'b0;
      repeat (16) @(negedge ref_clk);
      rst = 1'b0;
      t_regs();
      t_rates();
      t_sync();
      stop_test();
   end
   // Watchdog well beyond the expected run
   initial begin
      #(50 * 20000);
      errors++;
      stop_test();
   end
endmodule : msf_filter_range_config_tb_top
bind msf_filter_range_config msf_filter_range_config_chk #(.TICKS_32K(TICKS_32K)) i_chk (
   .ref_clk(ref_clk), .rst(rst), .regWrEn(regWrEn), .regRdEn(regRdEn),
   .regRdValid(regRdValid), .regAddr(regAddr), .regWrData(regWrData),
   .regRdData(regRdData), .fifoFullPolicy(fifoFullPolicy), .lowpassActive(lowpassActive),
   .sampleStrobe(sampleStrobe), .lowpassSelect(lowpassSelect),
   .filterBypassSelect(filterBypassSelect), .outputRate(outputRate),
   .gyroRangeSelect(gyroRangeSelect), .accelRangeSelect(accelRangeSelect),
   .syncTagBits(syncTagBits));
`default_nettype wire
